//--- verilog/mul_neg_pkg.sv
// Constants, modes and carrier types for the multiply, negate and idle execution datapath.
package mul_neg_pkg;

    // ****************************************
    // Widths and addressing
    // ****************************************
    localparam int          ADDR_W        = 12;
    localparam int          BANK_W        = ADDR_W - 8;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;

    // ****************************************
    // Opcode patterns
    // ****************************************
    localparam logic [7:0]  OPC_MUL_LIT   = 8'h0D;
    localparam logic [6:0]  OPC_MUL_REG   = 7'h01;
    localparam logic [6:0]  OPC_NEG       = 7'h36;
    localparam logic [3:0]  OPC_IDLE_HI   = 4'hF;
    localparam logic [15:0] OPC_IDLE_ZERO = 16'h0000;

    // ****************************************
    // Register port map and reset values
    // ****************************************
    localparam logic [1:0]  REG_CTRL      = 2'h0;
    localparam logic [1:0]  REG_PROD_LO   = 2'h1;
    localparam logic [1:0]  REG_PROD_HI   = 2'h2;
    localparam logic [1:0]  REG_STATUS    = 2'h3;
    localparam int          CTRL_EXT_BIT  = 0;
    localparam logic        EXT_EN_RST    = 1'b0;
    localparam logic [15:0] PROD_RST      = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [7:0]  BYTE_ONE      = 8'h01;
    localparam logic [7:0]  BYTE_MIN_NEG  = 8'h80;
    localparam logic [3:0]  NIBBLE_ZERO   = 4'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic [1:0] {OP_IDLE, OP_MUL_LIT, OP_MUL_REG, OP_NEG} op_t;

    typedef struct packed {
        logic negative;
        logic signed_excess_flag;
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } flags_t;

    localparam flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } mem_req_t;

endpackage

//--- verilog/operand_addr.sv
// Data-memory address former for byte operands: bank, access bank and indexed offset.
`timescale 1ns/10ps
`default_nettype none
module operand_addr
    import mul_neg_pkg::*;
(
    input  wire logic [7:0]        fld,
    input  wire logic              bank_sel,
    input  wire logic              ext_en,
    input  wire logic [BANK_W-1:0] bank_selector_reg,
    input  wire logic [ADDR_W-1:0] index_base,
    output logic      [ADDR_W-1:0] addr,
    output logic                   indexed
);

    always_comb
    begin
        indexed = 1'b0;
        if (bank_sel)
        begin
            addr = {bank_selector_reg, fld};
        end
        else if (ext_en && (fld <= INDEX_LIMIT))
        begin
            indexed = 1'b1;
            addr    = ADDR_W'(index_base + {{(ADDR_W-8){1'b0}}, fld});
        end
        // The access bank splits between the bottom of bank zero and the top bank.
        else if (fld < ACCESS_SPLIT)
        begin
            addr = {{BANK_W{1'b0}}, fld};
        end
        else
        begin
            addr = {{BANK_W{1'b1}}, fld};
        end
    end

endmodule // operand_addr
`default_nettype wire

//--- verilog/mul_negate_nop_exec.sv
// Execution datapath for literal multiply, register multiply, negate and idle instructions.
//
// Overview of operation
// - Literal multiply: accumulator times 8-bit literal, 16-bit product, high byte upper.
// - Both multiplies leave all status flags alone, zero product not flagged.
// - Register multiply: accumulator times addressed byte into the product pair.
// - Register multiply writes neither accumulator nor source byte, only product.
// - Addressing bit 0 picks access bank; 1 uses bank selector register.
// - Bit 0 with extended set: operand at or below 95 uses indexed offset.
// - Negate writes the two's complement of the addressed byte back in place.
// - Negate updates negative, overflow, carry, nibble carry and zero flags.
// - Negate opcode: upper seven bits 0110110, addressing bit, 8-bit operand.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module mul_negate_nop_exec
    import mul_neg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    output logic                   instr_ready,
    input  wire logic [7:0]        acc_value,
    input  wire logic [BANK_W-1:0] bank_selector_reg,
    input  wire logic [ADDR_W-1:0] index_base,
    output mem_req_t               mem_req,
    input  wire logic [7:0]        mem_rdata,
    output logic      [7:0]        product_high_byte,
    output logic      [7:0]        product_low_byte,
    output flags_t                 status_flags,
    input  wire bus_req_t          bus_req,
    output logic      [7:0]        bus_rdata
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        phase_t      phase;
        op_t         op;
        logic [7:0]  lit;
        mem_req_t    mem;
        logic [15:0] res;
        flags_t      fres;
        logic [15:0] prod;
        flags_t      flags;
        logic        ext_en;
        logic [7:0]  rdata;
    } state_t;

    localparam state_t ST_RST = '{
        phase : PH_Q1,
        op    : OP_IDLE,
        lit   : BYTE_ZERO,
        mem   : '{1'b0, 1'b0, {ADDR_W{1'b0}}, BYTE_ZERO},
        res   : PROD_RST,
        fres  : FLAGS_RST,
        prod  : PROD_RST,
        flags : FLAGS_RST,
        ext_en: EXT_EN_RST,
        rdata : BYTE_ZERO
    };

    state_t            s_r;
    state_t            s_nxt;
    logic [ADDR_W-1:0] calc_addr;
    logic              calc_indexed;
    logic [7:0]        neg_val;
    logic [7:0]        mul_operand;
    logic              dec_mul_lit;
    logic              dec_mul_reg;
    logic              dec_neg;
    logic              dec_idle;

    // ****************************************
    // Decode and operand address
    // ****************************************
    // Multiply, negate and idle patterns.
    assign dec_mul_lit = (instr_word[15:8] == OPC_MUL_LIT);
    assign dec_mul_reg = (instr_word[15:9] == OPC_MUL_REG);
    assign dec_idle    = (instr_word == OPC_IDLE_ZERO) || (instr_word[15:12] == OPC_IDLE_HI);
    assign dec_neg     = (instr_word[15:9] == OPC_NEG);

    operand_addr u_operand_addr (
        .fld              (instr_word[7:0]),
        .bank_sel         (instr_word[8]),
        .ext_en           (s_r.ext_en),
        .bank_selector_reg(bank_selector_reg),
        .index_base       (index_base),
        .addr             (calc_addr),
        .indexed          (calc_indexed)
    );

    assign neg_val     = 8'(~mem_rdata + BYTE_ONE);
    assign mul_operand = (s_r.op == OP_MUL_LIT) ? s_r.lit : mem_rdata;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.mem.rd = 1'b0;
        s_nxt.mem.wr = 1'b0;
        s_nxt.rdata  = BYTE_ZERO;
        unique case (s_r.phase)
            PH_Q1:
            begin
                // Take the word at the first phase.
                s_nxt.phase = PH_Q2;
                s_nxt.op    = OP_IDLE;
                s_nxt.lit   = instr_word[7:0];
                if (instr_valid && !dec_idle)
                begin
                    if (dec_mul_lit)
                    begin
                        s_nxt.op = OP_MUL_LIT;
                    end
                    else if (dec_mul_reg || dec_neg)
                    begin
                        s_nxt.op       = dec_neg ? OP_NEG : OP_MUL_REG;
                        s_nxt.mem.rd   = 1'b1;
                        s_nxt.mem.addr = calc_addr;
                    end
                end
            end
            PH_Q2:
            begin
                s_nxt.phase = PH_Q3;
            end
            PH_Q3:
            begin
                s_nxt.phase = PH_Q4;
                s_nxt.res   = 16'(acc_value) * 16'(mul_operand);
                if (s_r.op == OP_NEG)
                begin
                    // Result goes back to the same address.
                    s_nxt.mem.wr                  = 1'b1;
                    s_nxt.mem.wdata               = neg_val;
                    s_nxt.fres.negative           = neg_val[7];
                    s_nxt.fres.signed_excess_flag = (mem_rdata == BYTE_MIN_NEG);
                    s_nxt.fres.zero               = (neg_val == BYTE_ZERO);
                    s_nxt.fres.nibble_carry_flag  = (mem_rdata[3:0] == NIBBLE_ZERO);
                    s_nxt.fres.carry              = (mem_rdata == BYTE_ZERO);
                end
            end
            PH_Q4:
            begin
                s_nxt.phase = PH_Q1;
                // Multiplies touch only the product pair.
                if ((s_r.op == OP_MUL_LIT) || (s_r.op == OP_MUL_REG))
                begin
                    s_nxt.prod = s_r.res;
                end
                if (s_r.op == OP_NEG)
                begin
                    s_nxt.flags = s_r.fres;
                end
            end
        endcase
        // Mode changes apply from the next instruction taken; one in flight keeps its address.
        if (bus_req.wr && (bus_req.addr == REG_CTRL))
        begin
            s_nxt.ext_en = bus_req.wdata[CTRL_EXT_BIT];
        end
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                REG_CTRL:    s_nxt.rdata = {7'h00, s_r.ext_en};
                REG_PROD_LO: s_nxt.rdata = s_r.prod[7:0];
                REG_PROD_HI: s_nxt.rdata = s_r.prod[15:8];
                REG_STATUS:  s_nxt.rdata = {3'h0, s_r.flags};
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_r <= ST_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign instr_ready       = (s_r.phase == PH_Q1);
    assign mem_req           = s_r.mem;
    assign product_high_byte = s_r.prod[15:8];
    assign product_low_byte  = s_r.prod[7:0];
    assign status_flags      = s_r.flags;
    assign bus_rdata         = s_r.rdata;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_lit_product: assert property (
        (s_r.phase == PH_Q3 && s_r.op == OP_MUL_LIT) |-> ##2
        ({product_high_byte, product_low_byte} == $past(acc_value, 2) * $past(s_r.lit, 2)))
        else $error("Literal product wrong.");

    a_mul_flags_kept: assert property (
        (s_r.phase == PH_Q4 && (s_r.op == OP_MUL_LIT || s_r.op == OP_MUL_REG))
        |=> $stable(status_flags))
        else $error("Multiply changed flags.");

    a_reg_product: assert property (
        (s_r.phase == PH_Q3 && s_r.op == OP_MUL_REG) |-> ##2
        ({product_high_byte, product_low_byte} == $past(acc_value, 2) * $past(mem_rdata, 2)))
        else $error("Register product wrong.");

    a_mul_no_write: assert property (
        (s_r.phase == PH_Q1 && instr_valid && dec_mul_reg) |-> ##1 !mem_req.wr [*4])
        else $error("Register multiply wrote memory.");

    a_bank_addr: assert property (
        (instr_ready && instr_valid && dec_mul_reg && instr_word[8])
        |=> mem_req.rd && (mem_req.addr == {$past(bank_selector_reg), $past(instr_word[7:0])}))
        else $error("Banked address wrong.");

    a_index_addr: assert property (
        (instr_ready && instr_valid && dec_neg && !instr_word[8] && s_r.ext_en
         && instr_word[7:0] <= INDEX_LIMIT)
        |=> mem_req.addr == ADDR_W'($past(index_base) + ADDR_W'($past(instr_word[7:0]))))
        else $error("Indexed address wrong.");

    a_neg_write: assert property (
        (s_r.phase == PH_Q3 && s_r.op == OP_NEG)
        |=> mem_req.wr && (mem_req.wdata == 8'(BYTE_ZERO - $past(mem_rdata))))
        else $error("Negate result wrong.");

    a_neg_flags: assert property (
        (s_r.phase == PH_Q4 && s_r.op == OP_NEG)
        |=> status_flags.zero == (mem_req.wdata == BYTE_ZERO)
            && status_flags.negative == mem_req.wdata[7])
        else $error("Negate flags wrong.");

    a_neg_decode: assert property (
        (instr_ready && instr_valid && instr_word[15:9] == 7'h36) |=> s_r.op == OP_NEG)
        else $error("Negate not decoded.");

    a_idle_decode: assert property (
        (instr_ready && instr_valid && instr_word[15:12] == 4'hF)
        |=> s_r.op == OP_IDLE && !mem_req.rd ##2 !mem_req.wr)
        else $error("Idle word acted.");

    // The last edge that still sees reset leaves phase one standing for one more cycle.
    // Attempts therefore start only once reset is seen low.
    a_phase_walk: assert property (
        (!sys_rst && instr_ready) |=> !instr_ready [*3] ##1 instr_ready)
        else $error("Instruction cycle not four phases.");

    c_lit_mul: cover property (s_r.phase == PH_Q4 && s_r.op == OP_MUL_LIT);
    c_reg_mul: cover property (s_r.phase == PH_Q4 && s_r.op == OP_MUL_REG);
    c_neg_zero: cover property (s_r.phase == PH_Q4 && s_r.op == OP_NEG && s_r.fres.carry);
    c_indexed: cover property (instr_ready && instr_valid && calc_indexed);

endmodule // mul_negate_nop_exec
`default_nettype wire

//--- verif/tb_mul_negate_nop_exec.sv
// Self-checking random testbench for the multiply, negate and idle execution datapath.
`timescale 1ns/10ps
`default_nettype none
module tb_mul_negate_nop_exec
    import mul_neg_pkg::*;
;
    // ****************************************
    // Stimulus signals and expected state
    // ****************************************
    logic              clk               = 1'b0;
    logic              sys_rst           = 1'b1;
    logic              instr_valid       = 1'b0;
    logic [15:0]       instr_word        = 16'h0000;
    logic              instr_ready;
    logic [7:0]        acc_value         = 8'h00;
    logic [BANK_W-1:0] bank_selector_reg = '0;
    logic [ADDR_W-1:0] index_base        = '0;
    mem_req_t          mem_req;
    logic [7:0]        mem_rdata         = 8'h00;
    logic [7:0]        product_high_byte;
    logic [7:0]        product_low_byte;
    flags_t            status_flags;
    bus_req_t          bus_req           = '0;
    logic [7:0]        bus_rdata;
    int                fails             = 0;
    int                compares          = 0;
    logic              ext_on            = 1'b0;
    logic [15:0]       exp_prod          = PROD_RST;
    flags_t            exp_flags         = FLAGS_RST;

    always #5 clk = ~clk;

    mul_negate_nop_exec u_dut (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .instr_valid       (instr_valid),
        .instr_word        (instr_word),
        .instr_ready       (instr_ready),
        .acc_value         (acc_value),
        .bank_selector_reg (bank_selector_reg),
        .index_base        (index_base),
        .mem_req           (mem_req),
        .mem_rdata         (mem_rdata),
        .product_high_byte (product_high_byte),
        .product_low_byte  (product_low_byte),
        .status_flags      (status_flags),
        .bus_req           (bus_req),
        .bus_rdata         (bus_rdata)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus_op(input logic wr, input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{wr, ~wr, a, d};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
    endtask

    // Only bit 0 of the control byte has a defined meaning, so the rest is masked.
    task automatic read_all();
        logic [7:0] m;
        logic [7:0] e;
        for (int a = 0; a < 4; a++)
        begin
            bus_op(1'b0, a[1:0], 8'h00);
            m = (a == 0) ? 8'h01 : 8'hFF;
            e = (a == 0) ? {7'h00, ext_on} : (a == 1) ? exp_prod[7:0] :
                (a == 2) ? exp_prod[15:8] : {3'h0, exp_flags};
            check("bus_rdata", 32'(bus_rdata & m), 32'(e & m)); // register readback
        end
    endtask

    function automatic logic [ADDR_W-1:0] addr_exp(input logic [7:0] f, input logic a,
            input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] ib);
        if (a)
            addr_exp = {b, f};
        else if (ext_on && f <= INDEX_LIMIT)
            addr_exp = ib + {{BANK_W{1'b0}}, f};
        else
            addr_exp = (f < ACCESS_SPLIT) ? {{BANK_W{1'b0}}, f} : {{BANK_W{1'b1}}, f};
    endfunction

    // Finishes at a negedge of a Q4 cycle, the point at which exec expects to start.
    task automatic align();
        int n;
        n = 0;
        @(negedge clk);
        while (instr_ready !== 1'b1 && n < 8)
        begin
            n++;
            @(negedge clk);
        end
        if (n >= 8)
        begin
            fails++;
            print_verdict();
        end
        repeat (3) @(negedge clk);
    endtask

    // The previous instruction's result is checked in the Q1 of this one.
    task automatic exec(input logic [15:0] w, input logic [7:0] acc, input logic [7:0] d,
            input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] ib, input logic junk);
        logic              lit;
        logic              rg;
        logic              ng;
        logic [7:0]        res;
        logic [ADDR_W-1:0] ea;
        lit = (w[15:8] == OPC_MUL_LIT);
        rg = (w[15:9] == OPC_MUL_REG);
        ng = (w[15:9] == OPC_NEG);
        ea = addr_exp(w[7:0], w[8], b, ib);
        res = ~d + 8'h01;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        bank_selector_reg <= b;
        index_base <= ib;
        @(negedge clk);
        check("instr_ready", 32'(instr_ready), 32'h0000_0001); // decode phase
        check("product", 32'({product_high_byte, product_low_byte}), 32'(exp_prod));
        check("status_flags", 32'(status_flags), 32'(exp_flags)); // flag result
        @(posedge clk);
        instr_valid <= junk;
        instr_word <= {OPC_NEG, 1'b1, 8'h00};
        bank_selector_reg <= ~b;
        index_base <= ~ib;
        @(negedge clk);
        check("mem_req.rd", 32'(mem_req.rd), 32'(rg | ng)); // opcode decode
        if (rg | ng)
            check("mem_req.addr", 32'(mem_req.addr), 32'(ea)); // operand address
        @(posedge clk);
        mem_rdata <= d;
        acc_value <= acc;
        @(negedge clk);
        check("mem_req.rd", 32'(mem_req.rd), 32'h0000_0000); // single read
        @(posedge clk);
        mem_rdata <= ~d;
        acc_value <= ~acc;
        instr_valid <= 1'b0;
        @(negedge clk);
        check("mem_req.rd", 32'(mem_req.rd), 32'h0000_0000); // late words refused
        check("mem_req.wr", 32'(mem_req.wr), 32'(ng)); // write for negate only, no source write otherwise
        if (ng)
        begin
            check("mem_req.addr", 32'(mem_req.addr), 32'(ea)); // write address
            check("mem_req.wdata", 32'(mem_req.wdata), 32'(res)); // negated value
            exp_flags = '{res[7], d == BYTE_MIN_NEG, res == BYTE_ZERO,
                          d[3:0] == NIBBLE_ZERO, d == BYTE_ZERO};
        end
        if (lit)
            exp_prod = {8'h00, acc} * {8'h00, w[7:0]};
        if (rg)
            exp_prod = {8'h00, acc} * {8'h00, d};
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [31:0] r;
        logic [31:0] q;
        logic [15:0] w;
        void'($urandom(91645));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check("instr_ready", 32'(instr_ready), 32'h0000_0001); // ready after reset
        read_all();
        bus_op(1'b1, REG_PROD_LO, 8'hA5);
        bus_op(1'b1, REG_STATUS, 8'h1F);
        read_all();
        $display("test reset and register map done");
        align();
        exec({OPC_MUL_LIT, 8'hC4}, 8'hE2, 8'h11, 4'h3, 12'h123, 1'b0);
        exec({OPC_MUL_REG, 1'b1, 8'h20}, 8'hC4, 8'hB5, 4'h5, 12'h0F0, 1'b1);
        exec({OPC_NEG, 1'b1, 8'h21}, 8'h00, 8'h3A, 4'hA, 12'h200, 1'b1);
        exec({OPC_NEG, 1'b0, 8'h5F}, 8'h00, 8'h80, 4'h1, 12'h7A0, 1'b0);
        exec({OPC_MUL_LIT, 8'h00}, 8'h00, 8'h00, 4'h2, 12'h000, 1'b0);
        exec(OPC_IDLE_ZERO, 8'h77, 8'h00, 4'h6, 12'h001, 1'b1);
        exec({OPC_NEG, 1'b0, 8'h60}, 8'h01, 8'h00, 4'h7, 12'h002, 1'b0);
        exec({OPC_IDLE_HI, 12'h123}, 8'h55, 8'h10, 4'h0, 12'h003, 1'b0);
        // A near miss of the negate pattern must act as no instruction at all.
        exec(16'h6E21, 8'h12, 8'h34, 4'h1, 12'h010, 1'b0);
        exec({OPC_MUL_REG, 1'b0, 8'h00}, 8'hFF, 8'hFF, 4'hF, 12'hFFF, 1'b0);
        $display("test fixed cases done");
        bus_op(1'b1, REG_CTRL, BYTE_ONE);
        ext_on = 1'b1;
        read_all();
        align();
        exec({OPC_NEG, 1'b0, 8'h5F}, 8'h00, 8'h01, 4'h2, 12'hFD0, 1'b0);
        exec({OPC_MUL_REG, 1'b0, 8'h60}, 8'h02, 8'h90, 4'h2, 12'h400, 1'b0);
        exec({OPC_MUL_REG, 1'b0, 8'h00}, 8'h03, 8'h08, 4'h9, 12'h3FF, 1'b1);
        exec({OPC_NEG, 1'b1, 8'h10}, 8'h00, 8'h0F, 4'h9, 12'h3FF, 1'b0);
        $display("test indexed addressing done");
        for (int i = 0; i < 200; i++)
        begin
            r = $urandom;
            case (r[31:30])
                2'd0: w = {OPC_MUL_LIT, r[7:0]};
                2'd1: w = {OPC_MUL_REG, r[8:0]};
                2'd2: w = {OPC_NEG, r[8:0]};
                default: w = {OPC_IDLE_HI, r[11:0]};
            endcase
            if (i == 100)
            begin
                bus_op(1'b1, REG_CTRL, BYTE_ZERO);
                ext_on = 1'b0;
                read_all();
                align();
            end
            q = $urandom;
            exec(w, r[16:9], r[24:17], r[28:25], q[11:0], r[29]);
        end
        exec(OPC_IDLE_ZERO, 8'h00, 8'h00, 4'h0, 12'h000, 1'b0);
        read_all();
        $display("test random instructions done");
        print_verdict();
    end

    initial
    begin
        #100us;
        fails++;
        print_verdict();
    end
endmodule // tb_mul_negate_nop_exec
`default_nettype wire
